// [rtl/clk_ctl_consts.svh]
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLK_CTL_CONSTS_SVH
`define CLK_CTL_CONSTS_SVH
`define PLL_CTRL_OFS 12'h000
`define MODE_CTRL_OFS 12'h004
`define STATUS_OFS 12'h008
`define PLL_CTRL_RST 8'h00
`define PRE_DIV_BIT 4
`define POST_EN_BIT 5
`define MULT_EN_BIT 6
`define POST_SEL_BIT 7
`define MODE_IDLE_BIT 0
`define MODE_SCS_LO 1
`define MODE_SEC_EN_BIT 3
`define MODE_SLEEP_BIT 4
`define MODE_WAKE_BIT 5
`define CPU_START_CYCLES 10
`endif

// [rtl/clk_ctl_pkg.sv]
// Types of the clock control block
package clk_ctl_pkg;
    typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} clk_src_e;
    typedef enum {ST_CONFIG, ST_RUN, ST_IDLE, ST_WAIT_SEC, ST_WAKE} pwr_state_e;
endpackage

// [rtl/clock_pll_and_idle_control.sv]
// Clock prescaler, multiplier selection, postscaler and idle mode sequencing
//
// Contract
// - Internal RC clocks configuration until run
// - Internal RC runs when selected or needed
// - Default config bit starts on internal RC
// - Prescaler divides by 2 or 3
// - Multiplier by five when enabled
// - Postscaler bypass, else divide 2 or 3
// - Dividers usable with or without multiplier
// - Primary idle keeps primary clock running
// - Primary idle stops CPU, flag stays set
// - Primary wake after start delay, bits kept
// - Secondary switch stops primary, flags update
// - Secondary wake after delay, bits kept
// - Sleep ignored when secondary disabled
// - Peripheral clocks held until secondary runs
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "clk_ctl_consts.svh"
module clock_pll_and_idle_control
    import clk_ctl_pkg::*;
#(
    parameter int CPU_START_CYCLES = `CPU_START_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic default_clock_cfg_bit,
    input wire logic [1:0] primary_osc_select_cfg,
    input wire logic multiplier_supported,
    input wire logic fail_safe_en,
    input wire logic watchdog_en,
    input wire logic two_speed_en,
    input wire logic secondary_osc_running,
    input wire logic config_done,
    output logic internal_rc_osc_en,
    output logic primary_osc_en,
    output logic multiplier_on,
    output logic [1:0] sys_clk_src,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic pre_tick,
    output logic post_tick
);
    if (CPU_START_CYCLES < 1 || CPU_START_CYCLES > 255) begin : g_bad_start_cycles
        $error("CPU_START_CYCLES out of range");
    end

    logic [7:0] pll_ctrl_q;
    logic idle_on_sleep_enable_q;
    logic [1:0] clock_source_select_q;
    logic secondary_osc_enable_q;
    logic osc_startup_done_flag_q;
    logic secondary_osc_active_flag_q;
    pwr_state_e state_q;
    logic [7:0] delay_q;
    logic [3:0] cfg_s1_q, cfg_s2_q;
    logic sec_s1_q, sec_s2_q;
    logic [1:0] pre_cnt_q, post_cnt_q;
    logic [1:0] pre_ratio_q, post_ratio_q;
    logic post_on_q;
    logic wr_en, rd_en, sleep_cmd, wake_cmd, sec_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign sleep_cmd = wr_en && paddr == `MODE_CTRL_OFS && pwdata[`MODE_SLEEP_BIT];
    assign wake_cmd = wr_en && paddr == `MODE_CTRL_OFS && pwdata[`MODE_WAKE_BIT];
    assign sec_ok = sec_s2_q;

    // Straps and the oscillator status come from outside this clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_s1_q <= 4'h0;
            cfg_s2_q <= 4'h0;
            sec_s1_q <= 1'b0;
            sec_s2_q <= 1'b0;
        end else begin
            cfg_s1_q <= {primary_osc_select_cfg, config_done, default_clock_cfg_bit};
            cfg_s2_q <= cfg_s1_q;
            sec_s1_q <= secondary_osc_running;
            sec_s2_q <= sec_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_ctrl_q <= `PLL_CTRL_RST;
        end else if (wr_en && paddr == `PLL_CTRL_OFS) begin
            pll_ctrl_q <= {pwdata[7:4] & {1'b1, multiplier_supported, 2'h3}, 4'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_on_sleep_enable_q <= 1'b0;
            clock_source_select_q <= 2'h0;
            secondary_osc_enable_q <= 1'b0;
        end else if (wr_en && paddr == `MODE_CTRL_OFS && !pwdata[`MODE_SLEEP_BIT]
            && !pwdata[`MODE_WAKE_BIT]) begin
            // Strobe writes leave the mode bits alone, so a wake keeps them
            // Wake never touches these bits
            idle_on_sleep_enable_q <= pwdata[`MODE_IDLE_BIT];
            clock_source_select_q <= pwdata[`MODE_SCS_LO+1:`MODE_SCS_LO];
            secondary_osc_enable_q <= pwdata[`MODE_SEC_EN_BIT];
        end
    end

    // Power sequencer; sleep is accepted only with idle enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_CONFIG;
            delay_q <= 8'h00;
        end else begin
            case (state_q)
                ST_CONFIG: if (cfg_s2_q[1]) state_q <= ST_RUN;
                ST_RUN: begin
                    if (sleep_cmd && idle_on_sleep_enable_q) begin
                        if (clock_source_select_q != 2'h1) begin
                            state_q <= ST_IDLE;
                        end else if (secondary_osc_enable_q) begin
                            state_q <= sec_ok ? ST_IDLE : ST_WAIT_SEC;
                        end
                        // Disabled secondary: sleep ignored
                    end
                end
                ST_WAIT_SEC: if (sec_ok) state_q <= ST_IDLE;
                ST_IDLE: begin
                    if (wake_cmd) begin
                        state_q <= ST_WAKE;
                        delay_q <= 8'(CPU_START_CYCLES);
                    end
                end
                ST_WAKE: begin
                    if (delay_q == 8'h01) state_q <= ST_RUN;
                    delay_q <= delay_q - 8'h01;
                end
                default: state_q <= ST_CONFIG;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_startup_done_flag_q <= 1'b0;
            secondary_osc_active_flag_q <= 1'b0;
        end else if (state_q != ST_CONFIG && clock_source_select_q == 2'h1 && sec_ok) begin
            osc_startup_done_flag_q <= 1'b0;
            secondary_osc_active_flag_q <= 1'b1;
        end else if (state_q != ST_CONFIG && clock_source_select_q != 2'h1) begin
            osc_startup_done_flag_q <= !(clock_source_select_q[0] || clock_source_select_q == 2'h0
                && cfg_s2_q[0]);
            secondary_osc_active_flag_q <= 1'b0;
        end
    end

    // Ratios latch only at a divider wrap so no short pulse appears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_q <= 2'h0;
            pre_ratio_q <= 2'h1;
            pre_tick <= 1'b0;
        end else begin
            pre_tick <= pre_cnt_q == pre_ratio_q;
            if (pre_cnt_q >= pre_ratio_q) begin
                pre_cnt_q <= 2'h0;
                pre_ratio_q <= pll_ctrl_q[`PRE_DIV_BIT] ? 2'h2 : 2'h1;
            end else begin
                pre_cnt_q <= pre_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt_q <= 2'h0;
            post_ratio_q <= 2'h0;
            post_on_q <= 1'b0;
            post_tick <= 1'b0;
        end else if (pre_tick) begin // Counts prescaler ticks only; the multiplier is not in this path
            post_tick <= !post_on_q || post_cnt_q == post_ratio_q;
            if (!post_on_q || post_cnt_q >= post_ratio_q) begin
                post_cnt_q <= 2'h0;
                post_on_q <= pll_ctrl_q[`POST_EN_BIT];
                post_ratio_q <= pll_ctrl_q[`POST_SEL_BIT] ? 2'h1 : 2'h2;
            end else begin
                post_cnt_q <= post_cnt_q + 2'h1;
            end
        end else begin
            post_tick <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_rc_osc_en <= 1'b1;
            primary_osc_en <= 1'b0;
            multiplier_on <= 1'b0;
            sys_clk_src <= SRC_INTERNAL;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
        end else begin
            internal_rc_osc_en <= state_q == ST_CONFIG || sys_clk_src == SRC_INTERNAL
                || fail_safe_en || watchdog_en || two_speed_en;
            primary_osc_en <= state_q != ST_CONFIG && !secondary_osc_active_flag_q;
            multiplier_on <= pll_ctrl_q[`MULT_EN_BIT] && multiplier_supported;
            if (state_q == ST_CONFIG) begin
                sys_clk_src <= SRC_INTERNAL;
            end else if (clock_source_select_q == 2'h1) begin
                sys_clk_src <= SRC_SECONDARY;
            end else if (clock_source_select_q == 2'h0 && cfg_s2_q[0]) begin
                sys_clk_src <= SRC_INTERNAL;
            end else begin
                sys_clk_src <= cfg_s2_q[3:2] == 2'h3 ? SRC_INTERNAL : SRC_PRIMARY;
            end
            cpu_clk_en <= state_q == ST_RUN;
            periph_clk_en <= state_q inside {ST_RUN, ST_IDLE, ST_WAKE};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr inside {`PLL_CTRL_OFS, `MODE_CTRL_OFS,
                `STATUS_OFS});
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `PLL_CTRL_OFS: prdata <= {24'h0, pll_ctrl_q};
                    `MODE_CTRL_OFS: prdata <= {28'h0, secondary_osc_enable_q,
                        clock_source_select_q, idle_on_sleep_enable_q};
                    `STATUS_OFS: prdata <= {24'h0, 1'(state_q == ST_WAKE),
                        1'(state_q == ST_WAIT_SEC), 1'(state_q == ST_IDLE), cpu_clk_en,
                        2'(sys_clk_src), secondary_osc_active_flag_q, osc_startup_done_flag_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && wake_cmd |=> state_q == ST_WAKE [*1] ##0 !cpu_clk_en)
        else $error("wake did not wait");
    a_sleep_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_RUN && sleep_cmd && clock_source_select_q == 2'h1
        && !secondary_osc_enable_q |=> state_q == ST_RUN)
        else $error("sleep not ignored");
    a_sec_flags: assert property (@(posedge pclk) disable iff (!presetn)
        secondary_osc_active_flag_q |-> !osc_startup_done_flag_q) else $error("flags clash");
    a_mult_forced: assert property (@(posedge pclk) disable iff (!presetn)
        !multiplier_supported |=> !multiplier_on) else $error("multiplier not forced off");
    a_idle_cpu: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE |=> !cpu_clk_en) else $error("cpu runs in idle");
    a_hold_periph: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_WAIT_SEC |=> !periph_clk_en) else $error("peripherals not held");
    a_config_rc: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_CONFIG |=> internal_rc_osc_en) else $error("rc off in config");
    a_pre_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        pre_tick |=> !pre_tick) else $error("prescaler tick too close");

    // Wake timing, flag behaviour and divider bypass
    a_wake_stay: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_WAKE && delay_q != 8'h01 |=> state_q == ST_WAKE && !cpu_clk_en)
        else $error("wake ended early");
    a_wake_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && wake_cmd |=> $stable(idle_on_sleep_enable_q)
        && $stable(clock_source_select_q)) else $error("wake changed mode bits");
    a_sec_wait: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_RUN && sleep_cmd && idle_on_sleep_enable_q
        && clock_source_select_q == 2'h1 && secondary_osc_enable_q && !sec_ok
        |=> state_q == ST_WAIT_SEC) else $error("idle entered before oscillator");
    a_primary_off: assert property (@(posedge pclk) disable iff (!presetn)
        secondary_osc_active_flag_q |=> !primary_osc_en) else $error("primary still on");
    a_idle_periph: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE |=> periph_clk_en) else $error("peripherals stopped in idle");
    a_startup_kept: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && clock_source_select_q == 2'h2
        |=> osc_startup_done_flag_q) else $error("startup flag lost in idle");
    a_post_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        pre_tick && !post_on_q |=> post_tick) else $error("postscaler not bypassed");
    a_default_rc: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_RUN && clock_source_select_q == 2'h0 && cfg_s2_q[0]
        |=> sys_clk_src == SRC_INTERNAL) else $error("default source not internal");
    a_rc_needed: assert property (@(posedge pclk) disable iff (!presetn)
        fail_safe_en || watchdog_en || two_speed_en |=> internal_rc_osc_en)
        else $error("internal oscillator off while needed");
    c_idle: cover property (@(posedge pclk) state_q == ST_RUN ##1 state_q == ST_IDLE);
    c_wake: cover property (@(posedge pclk) state_q == ST_WAKE ##1 state_q == ST_RUN);
    c_wait: cover property (@(posedge pclk) state_q == ST_WAIT_SEC ##1 state_q == ST_IDLE);
    c_sleep_ignored: cover property (@(posedge pclk) state_q == ST_RUN && sleep_cmd
        && clock_source_select_q == 2'h1 && !secondary_osc_enable_q);
    c_post_div: cover property (@(posedge pclk) post_on_q && post_tick);
endmodule

// [test/sec_osc_model.sv]
// Secondary oscillator model that needs time to start after enable
`timescale 1ns/1ps
module sec_osc_model #(
    parameter int START_CYCLES = 30,
    parameter int PRIMARY_HZ = 25000000 // Bench primary source is Ethernet grade
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    output logic running
);
    if (PRIMARY_HZ != 25000000) begin : g_bad_primary
        $error("Primary source must be 25 MHz for Ethernet use");
    end

    int cnt_q;
    // Slow start so the idle entry sees a stopped oscillator first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            running <= 1'b0;
        end else if (!enable) begin
            cnt_q <= 0;
            running <= 1'b0;
        end else if (cnt_q < START_CYCLES) begin
            cnt_q <= cnt_q + 1;
        end else begin
            running <= 1'b1;
        end
    end
endmodule

// [test/testbench.sv]
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`include "clk_ctl_consts.svh"
module testbench;
    import clk_ctl_pkg::*;
    localparam int CS = 6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic dflt, mult_ok, wdog, sec_en, secondary_clocked_run, cfg_done, rc_en, pri_en, mult_on;
    logic cpu_en, per_en, pre_tick, post_tick, s0;
    logic [1:0] src;
    logic [1:0] posc;
    logic fsafe, tspd;
    logic [7:0] cfg [5] = '{8'h00, 8'h10, 8'h20, 8'hb0, 8'he0};
    int pre_p [5] = '{2, 3, 2, 3, 2};
    int post_p [5] = '{2, 3, 6, 6, 4};
    int err_count, checks_done, p;

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    clock_pll_and_idle_control #(.CPU_START_CYCLES(CS)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .default_clock_cfg_bit(dflt), .primary_osc_select_cfg(posc),
        .multiplier_supported(mult_ok), .fail_safe_en(fsafe), .watchdog_en(wdog),
        .two_speed_en(tspd), .secondary_osc_running(secondary_clocked_run), .config_done(cfg_done),
        .internal_rc_osc_en(rc_en), .primary_osc_en(pri_en), .multiplier_on(mult_on),
        .sys_clk_src(src), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .pre_tick(pre_tick), .post_tick(post_tick));

    sec_osc_model osc_u (.pclk(pclk), .presetn(presetn), .enable(sec_en), .running(secondary_clocked_run));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic period(input bit post, output int q);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((post ? post_tick : pre_tick) !== 1'b1 && n < 50);
        q = 0;
        do begin
            @(posedge pclk);
            q++;
        end while ((post ? post_tick : pre_tick) !== 1'b1 && q < 50);
    endtask

    // CPU held for the start delay, then runs; mode bits survive the wake
    task automatic wake_chk(input logic [7:0] mode);
        int n;
        bus(1'b1, `MODE_CTRL_OFS, 32'h20);
        repeat (CS) begin
            @(posedge pclk);
            chk(cpu_en, 1'b0);
        end
        n = 0;
        while (cpu_en !== 1'b1 && n < CS + 6) begin
            @(posedge pclk);
            n++;
        end
        chk(cpu_en, 1'b1);
        bus(1'b0, `MODE_CTRL_OFS, 32'h0);
        chk(rd, {28'h0, mode[3:0]});
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        give_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {mult_ok, wdog, sec_en, cfg_done, fsafe, tspd, posc} = '0;
        dflt = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(src, 2'd2);
        chk(rc_en, 1'b1);
        bus(1'b0, `PLL_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        cfg_done <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(src, 2'd2);
        chk(rc_en, 1'b1);
        bus(1'b1, `PLL_CTRL_OFS, 32'hff);
        bus(1'b0, `PLL_CTRL_OFS, 32'h0);
        chk(rd, 32'hb0);
        mult_ok <= 1'b1;
        bus(1'b1, `PLL_CTRL_OFS, 32'hff);
        repeat (4) @(posedge pclk);
        chk(mult_on, 1'b1);
        mult_ok <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(mult_on, 1'b0);
        mult_ok <= 1'b1;
        bus(1'b0, 12'h00c, 32'h0);
        chk(serr, 1'b1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `PLL_CTRL_OFS, {24'h0, cfg[i]});
            period(1'b0, p);
            period(1'b0, p);
            chk(p, pre_p[i]);
            period(1'b1, p);
            period(1'b1, p);
            chk(p, post_p[i]);
        end
        bus(1'b1, `MODE_CTRL_OFS, 32'h01);
        bus(1'b1, `MODE_CTRL_OFS, 32'h05);
        repeat (4) @(posedge pclk);
        chk(src, 2'd0);
        chk(rc_en, 1'b0);
        wdog <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(rc_en, 1'b1);
        wdog <= 1'b0;
        fsafe <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(rc_en, 1'b1);
        fsafe <= 1'b0;
        tspd <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(rc_en, 1'b1);
        tspd <= 1'b0;
        posc <= 2'b11;
        repeat (6) @(posedge pclk);
        chk({src, rc_en}, 3'b101);
        posc <= 2'b00;
        repeat (6) @(posedge pclk);
        chk(src, 2'd0);
        bus(1'b0, `STATUS_OFS, 32'h0);
        s0 = rd[0];
        chk(s0, 1'b1);
        bus(1'b1, `MODE_CTRL_OFS, 32'h15);
        repeat (3) @(posedge pclk);
        chk(cpu_en, 1'b0);
        chk({per_en, pri_en}, 2'b11);
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk({rd[5], rd[0]}, {1'b1, s0});
        wake_chk(8'h05);
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(rd[0], s0);
        bus(1'b1, `MODE_CTRL_OFS, 32'h03);
        bus(1'b1, `MODE_CTRL_OFS, 32'h13);
        repeat (3) @(posedge pclk);
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk({cpu_en, rd[5]}, 2'b10);
        sec_en <= 1'b1;
        bus(1'b1, `MODE_CTRL_OFS, 32'h0b);
        bus(1'b1, `MODE_CTRL_OFS, 32'h1b);
        repeat (3) @(posedge pclk);
        chk(per_en, 1'b0);
        repeat (60) @(posedge pclk);
        chk({per_en, src, pri_en}, 4'b1010);
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(rd[1:0], 2'b10);
        wake_chk(8'h0b);
        chk({secondary_clocked_run, src}, 3'b101);
        give_verdict();
    end
endmodule
